// ---- rtl/vnc_convert.sv ----
// vector number format converter: fifo, per-lane quantize and overflow, latency chain, wishbone
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "vnc_map.svh"
module vnc_convert #(
	parameter int                 LANES_PER_SAMPLE_PERIOD = 4,
	parameter int                 IN_W        = 16,
	parameter int                 IN_F        = 8,
	parameter bit                 IN_SIGNED   = 1'b1,
	parameter vnc_pkg::vnc_kind_t OUT_KIND    = vnc_pkg::VNC_KIND_FIXED,
	parameter int                 OUT_W       = 8,
	parameter int                 OUT_F       = 2,
	parameter vnc_pkg::vnc_fp_t   FP_FMT      = vnc_pkg::VNC_FP_SINGLE,
	parameter int                 FP_EXP_C    = 5,
	parameter int                 FP_FRAC_C   = 10,
	parameter int                 LATENCY     = 1,
	parameter bit                 DIST_PIPE   = 1'b0,
	parameter int                 FIFO_DEPTH  = 16,
	localparam int                EXP_W       = vnc_pkg::vnc_exp_w(FP_FMT, FP_EXP_C),
	localparam int                FRAC_W      = vnc_pkg::vnc_frac_w(FP_FMT, FP_FRAC_C),
	localparam int                LW          = (OUT_KIND == vnc_pkg::VNC_KIND_FIXED) ?
	                                            OUT_W : 1 + EXP_W + FRAC_W
) (
	// clock and reset
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	// freeze control
	input  wire logic                                 en_i,
	// input sample stream
	input  wire logic                                 in_valid_i,
	output logic                                      in_ready_o,
	input  wire logic [LANES_PER_SAMPLE_PERIOD*IN_W-1:0] in_data_i,
	// output sample stream
	output logic                                      out_valid_o,
	input  wire logic                                 out_ready_i,
	output logic [LANES_PER_SAMPLE_PERIOD*LW-1:0]     out_data_o,
	// wishbone slave
	input  wire logic                                 wb_cyc_i,
	input  wire logic                                 wb_stb_i,
	input  wire logic                                 wb_we_i,
	input  wire logic [7:0]                           wb_adr_i,
	input  wire logic [3:0]                           wb_sel_i,
	input  wire logic [31:0]                          wb_dat_i,
	output logic [31:0]                               wb_dat_o,
	output logic                                      wb_ack_o
);
	import vnc_pkg::*;

	localparam int  NL       = LANES_PER_SAMPLE_PERIOD;
	localparam bit  IS_FIX   = (OUT_KIND == VNC_KIND_FIXED);
	localparam int  SH       = IN_F - OUT_F;
	localparam int  SHP      = (SH > 0) ? SH : 1;
	localparam int  SHL      = (SH < 0) ? -SH : 0;
	localparam int  WW       = ((IN_W > OUT_W) ? IN_W : OUT_W) + 2 + SHL;
	localparam int  MW       = IS_FIX ? WW : IN_W;
	localparam bit  DIST_EFF = DIST_PIPE && (LATENCY >= 2);
	localparam int  TAIL     = LATENCY - 1 - (DIST_EFF ? 1 : 0);
	localparam int  BIAS     = (1 << (EXP_W - 1)) - 1;
	localparam int  EMAX     = (1 << EXP_W) - 1;
	localparam int  NW       = IN_W + FRAC_W + 1;
	localparam logic [WW-1:0]   QMASK = {WW{1'b1}} >> (WW - SHP);
	localparam logic [WW-1:0]   QHALF = {{(WW-1){1'b0}}, 1'b1} << (SHP - 1);
	localparam logic [IN_W-1:0] FHALF = {1'b1, {(IN_W-1){1'b0}}};

	// fixed quantization: scale to the output lsb and apply the rounding increment
	function automatic logic signed [WW-1:0] fix_quant(input logic [IN_W-1:0] x,
	                                                   input vnc_round_t rm);
		logic signed [WW-1:0] xe;
		logic signed [WW-1:0] fl;
		logic [WW-1:0]        rem;
		logic                 inc;
		xe  = IN_SIGNED ? $signed({{(WW-IN_W){x[IN_W-1]}}, x}) :
			$signed({{(WW-IN_W){1'b0}}, x});
		fl  = xe >>> SHP;
		rem = xe & QMASK;
		unique case (rm)
			VNC_RND_SYM:  inc = (rem > QHALF) | ((rem == QHALF) & ~xe[WW-1]);
			VNC_RND_CONV: inc = (rem > QHALF) | ((rem == QHALF) & fl[0]);
			default:      inc = 1'b0;
		endcase
		if (SH <= 0) begin
			fix_quant = xe <<< SHL;
		end else begin
			fix_quant = fl + $signed({{(WW-1){1'b0}}, inc});
		end
	endfunction : fix_quant

	// fixed overflow: clamp in saturate, keep the low bits otherwise
	function automatic logic [OUT_W:0] fix_ovf(input logic signed [WW-1:0] q,
	                                           input vnc_ovf_t om, input logic sgn);
		logic signed [WW-1:0] hi;
		logic signed [WW-1:0] lo;
		logic                 ov;
		hi = sgn ? $signed({{(WW-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}}) :
			$signed({{(WW-OUT_W){1'b0}}, {OUT_W{1'b1}}});
		lo = sgn ? ~hi : $signed({WW{1'b0}});
		ov = (q > hi) || (q < lo);
		if (ov && om == VNC_OVF_SAT) begin
			fix_ovf = {1'b1, (q > hi) ? hi[OUT_W-1:0] : lo[OUT_W-1:0]};
		end else begin
			fix_ovf = {ov, q[OUT_W-1:0]};
		end
	endfunction : fix_ovf

	// fixed to float: normalize, round the fraction, then range-check the exponent
	function automatic logic [EXP_W+FRAC_W+1:0] flt_conv(input logic [IN_W-1:0] x,
	                                                     input vnc_round_t rm, input vnc_ovf_t om);
		logic              s;
		logic [IN_W-1:0]   mag;
		logic [NW-1:0]     nrm;
		logic [FRAC_W-1:0] frac;
		logic [IN_W-1:0]   rem;
		logic [FRAC_W:0]   man;
		logic              inc;
		int                p;
		int                e;
		p    = 0;
		s    = IN_SIGNED & x[IN_W-1];
		mag  = s ? (~x + 1'b1) : x;
		for (int i = 0; i < IN_W; i++) begin
			if (mag[i]) begin
				p = i;
			end
		end
		nrm  = {mag, {(FRAC_W+1){1'b0}}} << (IN_W - 1 - p);
		frac = nrm[NW-2 -: FRAC_W];
		rem  = nrm[IN_W-1:0];
		unique case (rm)
			VNC_RND_SYM:  inc = (rem >= FHALF);
			VNC_RND_CONV: inc = (rem > FHALF) | ((rem == FHALF) & frac[0]);
			default:      inc = 1'b0;
		endcase
		man = {1'b0, frac} + {{FRAC_W{1'b0}}, inc};
		e   = p - IN_F + BIAS + (man[FRAC_W] ? 1 : 0);
		if (mag == '0 || e <= 0) begin
			flt_conv = {1'b0, s, {(EXP_W+FRAC_W){1'b0}}};
		end else if (e >= EMAX) begin
			flt_conv = (om == VNC_OVF_SAT) ?
				{1'b1, s, EXP_W'(EMAX - 1), {FRAC_W{1'b1}}} :
				{1'b1, s, {EXP_W{1'b1}}, {FRAC_W{1'b0}}};
		end else begin
			flt_conv = {1'b0, s, EXP_W'(e), man[FRAC_W-1:0]};
		end
	endfunction : flt_conv

	logic [4:0]        ctrl;
	logic              ovf_seen;
	logic              wb_ack_q;
	logic [31:0]       wb_dat_q;
	logic [NL*MW-1:0]  mid_q;
	logic              mid_v;
	logic [NL*LW-1:0]  pipe_d [TAIL+1];
	logic              pipe_v [TAIL+1];

	// fifo in front of the conversion; a beat is taken only while enabled
	wire                        fifo_v;
	wire [NL*IN_W-1:0]          fifo_d;
	wire [$clog2(FIFO_DEPTH)+1:0] fifo_lvl;
	wire                        adv = en_i & (out_ready_i | ~pipe_v[TAIL]);

	vnc_fifo #(
		.W     (NL*IN_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.hold_i     (~en_i),
		.wr_valid_i (in_valid_i & en_i),
		.wr_ready_o (in_ready_o),
		.wr_data_i  (in_data_i),
		.rd_valid_o (fifo_v),
		.rd_ready_i (adv),
		.rd_data_o  (fifo_d),
		.level_o    (fifo_lvl)
	);

	// live modes taken from the control register
	wire vnc_round_t rm  = vnc_round_t'(ctrl[`VNC_CTRL_RND_LSB +: 2]);
	wire vnc_ovf_t   om  = vnc_ovf_t'(ctrl[`VNC_CTRL_OVF_LSB +: 2]);
	wire             sgn = ctrl[`VNC_CTRL_SGN_BIT];

	// per-lane datapath; fixed: stage a quantizes, stage b handles overflow and packing; float: stage b converts
	wire [NL*MW-1:0] lane_mid;
	wire [NL*MW-1:0] b_in = DIST_EFF ? mid_q : lane_mid;
	wire [NL*LW-1:0] lane_res;
	wire [NL-1:0]    lane_ov;

	genvar l;
	generate
		for (l = 0; l < NL; l++) begin : g_lane
			if (IS_FIX) begin : g_fix
				assign lane_mid[l*MW +: MW] = fix_quant(fifo_d[l*IN_W +: IN_W], rm);
				assign {lane_ov[l], lane_res[l*LW +: LW]} = fix_ovf(b_in[l*MW +: MW], om, sgn);
			end else begin : g_flt
				// float keeps stage a as a plain pass-through so both stages balance poorly
				assign lane_mid[l*MW +: MW] = fifo_d[l*IN_W +: IN_W];
				assign {lane_ov[l], lane_res[l*LW +: LW]} = flt_conv(b_in[l*MW +: MW], rm, om);
			end
		end
	endgenerate

	// stage b sees a valid sample from the fifo or from the inner register
	wire b_valid = DIST_EFF ? mid_v : fifo_v;

	// optional register inside the conversion
	generate
		if (DIST_EFF) begin : g_mid
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					mid_q <= '0;
					mid_v <= 1'b0;
				end else if (adv) begin
					mid_q <= lane_mid;
					mid_v <= fifo_v;
				end
			end
		end else begin : g_nomid
			assign mid_q = '0;
			assign mid_v = 1'b0;
		end
	endgenerate

	// single register right after the conversion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pipe_d[0] <= '0;
			pipe_v[0] <= 1'b0;
		end else if (adv) begin
			pipe_d[0] <= lane_res;
			pipe_v[0] <= b_valid;
		end
	end

	// remaining latency as a shift register behind the conversion
	genvar k;
	generate
		for (k = 1; k <= TAIL; k++) begin : g_tail
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pipe_d[k] <= '0;
					pipe_v[k] <= 1'b0;
				end else if (adv) begin
					pipe_d[k] <= pipe_d[k-1];
					pipe_v[k] <= pipe_v[k-1];
				end
			end
		end
	endgenerate

	assign out_data_o  = pipe_d[TAIL];
	assign out_valid_o = pipe_v[TAIL];

	// wishbone decode; answer comes one cycle after the request, then ack drops
	wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_q;
	wire        hit_ctrl = (wb_adr_i[7:2] == `VNC_CTRL_OFS >> 2);
	wire        hit_stat = (wb_adr_i[7:2] == `VNC_STAT_OFS >> 2);
	wire        hit_info = (wb_adr_i[7:2] == `VNC_INFO_OFS >> 2);
	wire        wr_ctrl  = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];
	wire        clr_ovf  = wb_req & wb_we_i & hit_stat & wb_sel_i[0] &
	                       wb_dat_i[`VNC_STAT_OVF_BIT];
	wire        set_ovf  = adv & b_valid & (|lane_ov);
	wire [31:0] stat_w   = (32'(fifo_lvl) << `VNC_STAT_LVL_LSB) |
	                       (32'(pipe_v[TAIL]) << `VNC_STAT_VLD_BIT) |
	                       (32'(ovf_seen) << `VNC_STAT_OVF_BIT);
	wire [31:0] info_w   = (32'(NL[7:0]) << `VNC_INFO_LAN_LSB) |
	                       (32'(LATENCY[7:0]) << `VNC_INFO_LAT_LSB) |
	                       (32'(!IS_FIX) << `VNC_INFO_KND_BIT) |
	                       (32'(DIST_EFF) << `VNC_INFO_DST_BIT);
	wire [31:0] rd_mux   = hit_ctrl ? {27'h0000000, ctrl} :
	                       hit_stat ? stat_w :
	                       hit_info ? info_w : 32'h00000000;

	// control register, bus answer and the sticky overflow flag, where set beats clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= `VNC_CTRL_RST;
			ovf_seen <= 1'b0;
			wb_ack_q <= 1'b0;
			wb_dat_q <= 32'h00000000;
		end else begin
			wb_ack_q <= wb_req;
			if (wb_req) begin
				wb_dat_q <= wb_we_i ? 32'h00000000 : rd_mux;
			end
			if (wr_ctrl) begin
				ctrl <= wb_dat_i[4:0];
			end
			if (set_ovf) begin
				ovf_seen <= 1'b1;
			end else if (clr_ovf) begin
				ovf_seen <= 1'b0;
			end
		end
	end

	assign wb_ack_o = wb_ack_q;
	assign wb_dat_o = wb_dat_q;
endmodule : vnc_convert

// ---- rtl/vnc_map.svh ----
// register offsets, field positions, reset values and format widths of the vector converter
`ifndef VNC_MAP_SVH
`define VNC_MAP_SVH

// register byte offsets, one aligned 32-bit word each
`define VNC_CTRL_OFS     8'h00
`define VNC_STAT_OFS     8'h04
`define VNC_INFO_OFS     8'h08

// control register fields
`define VNC_CTRL_RND_LSB 0
`define VNC_CTRL_OVF_LSB 2
`define VNC_CTRL_SGN_BIT 4
`define VNC_CTRL_RST     5'h10

// status register fields
`define VNC_STAT_OVF_BIT 0
`define VNC_STAT_VLD_BIT 1
`define VNC_STAT_LVL_LSB 8

// info register fields
`define VNC_INFO_LAN_LSB 0
`define VNC_INFO_LAT_LSB 8
`define VNC_INFO_KND_BIT 16
`define VNC_INFO_DST_BIT 17

// floating-point format widths
`define VNC_SGL_EXP_W    8
`define VNC_SGL_FRAC_W   23
`define VNC_DBL_EXP_W    11
`define VNC_DBL_FRAC_W   52

`endif

// ---- rtl/vnc_pkg.sv ----
// types and format helpers of the vector number format converter
`include "vnc_map.svh"
package vnc_pkg;
	typedef enum logic [1:0] {VNC_RND_TRUNC, VNC_RND_SYM, VNC_RND_CONV, VNC_RND_RSVD} vnc_round_t;
	typedef enum logic [1:0] {VNC_OVF_SAT, VNC_OVF_WRAP, VNC_OVF_FLAG, VNC_OVF_RSVD} vnc_ovf_t;
	typedef enum logic {VNC_KIND_FIXED, VNC_KIND_FLOAT} vnc_kind_t;
	typedef enum logic [1:0] {VNC_FP_SINGLE, VNC_FP_DOUBLE, VNC_FP_CUSTOM} vnc_fp_t;

	// exponent width of a floating-point output format
	function automatic int vnc_exp_w(input vnc_fp_t f, input int custom_w);
		vnc_exp_w = (f == VNC_FP_SINGLE) ? `VNC_SGL_EXP_W :
			(f == VNC_FP_DOUBLE) ? `VNC_DBL_EXP_W : custom_w;
	endfunction : vnc_exp_w

	// fraction width of a floating-point output format
	function automatic int vnc_frac_w(input vnc_fp_t f, input int custom_w);
		vnc_frac_w = (f == VNC_FP_SINGLE) ? `VNC_SGL_FRAC_W :
			(f == VNC_FP_DOUBLE) ? `VNC_DBL_FRAC_W : custom_w;
	endfunction : vnc_frac_w
endpackage : vnc_pkg

// ---- rtl/vnc_fifo.sv ----
// sample fifo with a registered read port; hold stops the read register from loading, writes are gated by the caller
`timescale 1ns/1ps
module vnc_fifo #(
	parameter int W     = 64,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// freeze, no word moves into the read register while high; writes still go in
	input  wire logic                     hold_i,
	// write side
	input  wire logic                     wr_valid_i,
	output logic                          wr_ready_o,
	input  wire logic [W-1:0]             wr_data_i,
	// read side
	output logic                          rd_valid_o,
	input  wire logic                     rd_ready_i,
	output logic [W-1:0]                  rd_data_o,
	// fill level, memory plus read register
	output logic [$clog2(DEPTH)+1:0]      level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   cnt;

	// push and the move from memory into the read register
	wire         push     = wr_valid_i & wr_ready_o;
	// an idle read register must not pull a word while frozen, or state would move
	wire         load     = ~hold_i & (cnt != '0) & (~rd_valid_o | rd_ready_i);
	wire  [AW:0] next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

	// ready is registered from the next count so a full memory never takes a word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			cnt        <= '0;
			wr_ready_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
		end else begin
			cnt        <= next_cnt;
			wr_ready_o <= (next_cnt < (AW+1)'(DEPTH));
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (load) begin
				rd_ptr     <= rd_ptr + 1'b1;
				rd_data_o  <= mem[rd_ptr];
				rd_valid_o <= 1'b1;
			end else if (rd_ready_i) begin
				rd_valid_o <= 1'b0;
			end
		end
	end

	// storage has no reset, only the pointers matter
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= wr_data_i;
		end
	end

	// level counts the word parked in the read register as well
	always_comb begin
		level_o = {1'b0, cnt} + {{(AW+1){1'b0}}, rd_valid_o};
	end
endmodule : vnc_fifo

// ---- testbench/vnc_convert_props.sv ----
// port checker of the vector converter, bound from the bench top
`timescale 1ns/1ps
module vnc_convert_props #(
	parameter int DW = 32
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// streams and freeze
	input  wire logic          en_i,
	input  wire logic          in_valid_i,
	input  wire logic          in_ready_o,
	input  wire logic          out_valid_o,
	input  wire logic          out_ready_i,
	input  wire logic [DW-1:0] out_data_o,
	// wishbone
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [31:0]   wb_dat_o,
	input  wire logic          wb_ack_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// bus handshake: one ack per request, one cycle after it is taken
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack lasted more than one cycle");
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	a_write_dat_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("write answer carries data");
	// reset must win even though everything else is disabled under it
	a_reset_clears: assert property (disable iff (1'b0) rst_i |=>
		!out_valid_o && out_data_o == '0 && !in_ready_o && !wb_ack_o)
		else $error("outputs not cleared by reset");
	a_ready_release: assert property ($fell(rst_i) |=> in_ready_o)
		else $error("input not ready after reset release");
	// the first cycle after reset may still see ready rising, so it is skipped
	a_freeze_holds: assert property (!en_i && !$past(rst_i) |=>
		$stable(out_data_o) && $stable(out_valid_o) && $stable(in_ready_o))
		else $error("state moved while frozen");
	a_stall_holds: assert property (out_valid_o && !out_ready_i |=>
		out_valid_o && $stable(out_data_o))
		else $error("output changed under stall");

	c_freeze: cover property (!en_i && in_valid_i && in_ready_o);
	c_stall: cover property (out_valid_o && !out_ready_i);
	c_full: cover property (in_valid_i && !in_ready_o);
endmodule : vnc_convert_props

// ---- testbench/vnc_sink.sv ----
// downstream sink model: takes converted samples, can stall or pace slowly
`timescale 1ns/1ps
module vnc_sink #(
	parameter int DW = 32
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// pacing from the bench
	input  wire logic          stop_i,
	input  wire logic          slow_i,
	input  wire logic          en_i,
	// sample stream
	input  wire logic          valid_i,
	input  wire logic [DW-1:0] data_i,
	output logic               ready_o
);
	logic          tick;
	logic [DW-1:0] got[$];
	// slow pacing accepts every other cycle, a real consumer is rarely always ready
	assign ready_o = !stop_i && (!slow_i || tick);
	// a sample counts only when it really leaves, so a frozen chain is not counted twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick <= 1'b0;
		end else begin
			tick <= !tick;
			if (valid_i && ready_o && en_i) begin
				got.push_back(data_i);
			end
		end
	end
endmodule : vnc_sink

// ---- testbench/vnc_convert_tb_top.sv ----
// self-checking bench of the vector converter: register access, rounding table, stalls
`timescale 1ns/1ps
module vnc_convert_tb_top;
	localparam int LAT = 1;
	localparam int DEP = 16;
	localparam logic [63:0] BEAT = 64'h0120_7FFF_FEA0_0160;
	logic        clk, rst, en, iv, ir, ov, ordy, cyc, stb, we, ack, stop, slow;
	logic [63:0] idat;
	localparam logic [127:0] FEXP = 128'h3F90_0000_42FF_FE00_BFB0_0000_3FB0_0000;
	logic [31:0] odat, wdat, rdat, q, g, ddat;
	logic        fv, dv;
	logic [127:0] fdat;
	logic [7:0]  adr;
	logic [3:0]  sel;
	int          mismatches, n_tests, k, acc;

	vnc_convert #(.LANES_PER_SAMPLE_PERIOD(4), .LATENCY(LAT), .FIFO_DEPTH(DEP)) dut_u (
		.clk_i(clk), .rst_i(rst), .en_i(en), .in_valid_i(iv), .in_ready_o(ir),
		.in_data_i(idat), .out_valid_o(ov), .out_ready_i(ordy), .out_data_o(odat),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	vnc_sink #(.DW(32)) sink_u (.clk_i(clk), .rst_i(rst), .stop_i(stop), .slow_i(slow),
		.en_i(en), .valid_i(ov), .data_i(odat), .ready_o(ordy));
	// float and distributed-pipe copies on the same stream, always drained, bus idle
	vnc_convert #(.OUT_KIND(vnc_pkg::VNC_KIND_FLOAT), .LATENCY(LAT)) flt_u (
		.clk_i(clk), .rst_i(rst), .en_i(en), .in_valid_i(iv), .in_ready_o(),
		.in_data_i(idat), .out_valid_o(fv), .out_ready_i(1'b1), .out_data_o(fdat),
		.wb_cyc_i(1'b0), .wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0),
		.wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o());
	vnc_convert #(.LATENCY(3), .DIST_PIPE(1'b1)) dist_u (
		.clk_i(clk), .rst_i(rst), .en_i(en), .in_valid_i(iv), .in_ready_o(),
		.in_data_i(idat), .out_valid_o(dv), .out_ready_i(1'b1), .out_data_o(ddat),
		.wb_cyc_i(1'b0), .wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(8'h00), .wb_sel_i(4'h0),
		.wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o());

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic hang(input string w);
		mismatches++;
		$display("FAIL t=%0t timeout %s", $time, w);
		report_and_stop();
	endtask : hang
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string w);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL t=%0t %s got %h exp %h", $time, w, g, e);
		end
	endtask : check
	// one classic cycle, held until ack is sampled, then an idle cycle
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'h1; k = 0;
		do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 50);
		if (k >= 50) hang("bus");
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		check(q, e, "register read");
	endtask : rd
	// one beat, held until taken; valid is dropped only after the taking edge
	task automatic send(input logic [63:0] d);
		iv <= 1'b1; idat <= d; k = 0;
		do begin @(posedge clk); k++; end while (!(ir === 1'b1 && en === 1'b1) && k < 100);
		if (k >= 100) hang("input");
		iv <= 1'b0;
	endtask : send
	task automatic wait_out(input int n);
		k = 0;
		do begin @(posedge clk); k++; end while (sink_u.got.size() < n && k < 300);
		if (k >= 300) hang("output");
	endtask : wait_out
	// reference quantizer: 8 fraction bits in, 2 out, 8-bit result
	function automatic logic [7:0] cv(input logic [15:0] x, input int r, input int o, input bit s);
		int v;
		v = int'($signed(x)) >>> 6;
		if ((r == 1 || r == 2) && x[5:0] > 6'h20) v++;
		if (r == 1 && x[5:0] == 6'h20 && !x[15]) v++;
		if (r == 2 && x[5:0] == 6'h20 && v[0]) v++;
		if (o == 0 && v > (s ? 127 : 255)) v = s ? 127 : 255;
		if (o == 0 && v < (s ? -128 : 0)) v = s ? -128 : 0;
		return v[7:0];
	endfunction : cv

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		rst = 1'b1; en = 1'b1; iv = 1'b0; idat = '0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
		adr = 8'h00; sel = 4'h0; wdat = 32'h0; stop = 1'b0; slow = 1'b0;
		mismatches = 0; n_tests = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({31'h0, ov}, 32'h0, "valid after reset");
		check(odat, 32'h0, "data after reset");
		rd(8'h00, 32'h0000_0010);
		rd(8'h08, 32'h0000_0104);
		rd(8'h0C, 32'h0);
		xfer(1'b1, 8'h0C, 32'hFFFF_FFFF);
		rd(8'h00, 32'h0000_0010);
		$display("test registers done");
		// every rounding, overflow and sign setting on midpoints and an overflow lane
		for (int m = 0; m < 32; m++) begin
			xfer(1'b1, 8'h00, {27'h0, m[4], m[3:2], m[1:0]});
			send(BEAT);
			k = 0;
			do begin @(posedge clk); k++; end while (ov !== 1'b1 && k < 20);
			if (k >= 20) hang("latency");
			if (m == 0) begin
				check(k, LAT + 2, "latency");
				check({31'h0, fv}, 32'h1, "float valid");
				for (int l = 0; l < 4; l++) begin
					check(fdat[l*32 +: 32], FEXP[l*32 +: 32], "float lane");
				end
			end
			wait_out(1);
			// the distributed copy runs in reset mode: signed, saturate, truncate
			if (m == 0) begin
				@(posedge clk);
				for (int l = 3; l >= 0; l--) q = {q[23:0], cv(BEAT[l*16 +: 16], 0, 0, 1'b1)};
				check({31'h0, dv}, 32'h1, "distributed valid");
				check(ddat, q, "distributed lanes");
			end
			for (int l = 3; l >= 0; l--) q = {q[23:0], cv(BEAT[l*16 +: 16], m[1:0], m[3:2], m[4])};
			g = sink_u.got.pop_front();
			check({16'h0, g[15:0]}, {16'h0, q[15:0]}, "lo");
			check({16'h0, g[31:16]}, {16'h0, q[31:16]}, "hi");
		end
		rd(8'h04, 32'h0000_0001);
		xfer(1'b1, 8'h04, 32'h0000_0001);
		rd(8'h04, 32'h0);
		$display("test quantize done");
		// frozen: a beat inside stays in the fifo memory and an offered beat is not taken
		send(BEAT);
		en <= 1'b0;
		@(posedge clk);
		iv <= 1'b1; idat <= BEAT;
		repeat (6) @(posedge clk);
		check({31'h0, ov}, 32'h0, "moved while frozen");
		rd(8'h04, 32'h0000_0100);
		en <= 1'b1; iv <= 1'b0;
		wait_out(1);
		repeat (10) @(posedge clk);
		check(sink_u.got.size(), 1, "beats after freeze");
		void'(sink_u.got.pop_front());
		$display("test freeze done");
		// fill with the sink stopped, then drain it slowly and check order
		xfer(1'b1, 8'h00, 32'h0000_0014);
		stop <= 1'b1; acc = 0; iv <= 1'b1; idat <= '0;
		repeat (40) begin
			@(posedge clk);
			if (ir === 1'b1) begin acc++; idat <= {4{16'(acc * 64)}}; end
		end
		iv <= 1'b0;
		check(acc, DEP + 2, "accepted while stalled");
		// the frozen beat overflowed a lane under the last loop setting (overflow field 3), so the sticky flag is set
		rd(8'h04, 32'h0000_1103);
		stop <= 1'b0; slow <= 1'b1;
		wait_out(DEP + 2);
		for (int i = 0; i < DEP + 2; i++) begin
			check(sink_u.got.pop_front(), {4{i[7:0]}}, "order");
		end
		slow <= 1'b0;
		$display("test fill done");
		// reset with a sample held at the stalled output
		stop <= 1'b1;
		send(BEAT);
		repeat (4) @(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		check({30'h0, ov, ir}, 32'h0, "flags in reset");
		check(odat, 32'h0, "data in reset");
		rst <= 1'b0; stop <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0000_0010);
		$display("test reset done");
		report_and_stop();
	end
endmodule : vnc_convert_tb_top

bind vnc_convert vnc_convert_props #(.DW(LANES_PER_SAMPLE_PERIOD * LW)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .in_valid_i(in_valid_i),
	.in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
	.out_data_o(out_data_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
